/* File: common/crmc_pkg.sv */
// Package with the register map, field layout and timing constants of the clock/reset block.
package crmc_pkg;
  // ******************************
  // Register map
  // ******************************
  localparam logic [4:0] SYSCTL_OFS = 5'h00;
  localparam logic [4:0] OSCCTL_OFS = 5'h04;
  localparam logic [4:0] STBYCTL_OFS = 5'h08;
  localparam logic [4:0] EXTSEL_OFS = 5'h0C;
  localparam logic [4:0] SPDSEL_OFS = 5'h10;
  localparam logic [4:0] RSTFLG_OFS = 5'h14;
  localparam logic [31:0] SYSCTL_RST = 32'h0001_0000;
  localparam logic [31:0] OSCCTL_RST = 32'h8001_0030;
  localparam logic [31:0] STBYCTL_RST = 32'h0000_0103;
  localparam logic [31:0] EXTSEL_RST = 32'h0000_721E;
  localparam logic [31:0] SPDSEL_RST = 32'h0000_0000;
  // Writable bits of each register; other bits read as their reset value, except the OSC_WURUN and SPD_STATE status bits and the read-only RSTFLG flags.
  localparam logic [31:0] SYSCTL_WMASK = 32'h0013_3707;
  localparam logic [31:0] OSCCTL_WMASK = 32'hFFFF_CF08;
  localparam logic [31:0] STBYCTL_WMASK = 32'h0001_0307;
  localparam logic [31:0] EXTSEL_WMASK = 32'h0000_0001;
  localparam logic [31:0] SPDSEL_WMASK = 32'h0000_0002;
  // ******************************
  // Field positions
  // ******************************
  localparam int SYS_ADCSTOP = 20;
  localparam int SYS_CKOUT = 16;
  localparam int SYS_PBYP = 13;
  localparam int SYS_PBASE = 12;
  localparam int SYS_PRE = 8;
  localparam int SYS_GEAR = 0;
  localparam int OSC_WUH = 20;
  localparam int OSC_WUHS = 19;
  localparam int OSC_XUSE = 18;
  localparam int OSC_HSSEL = 17;
  localparam int OSC_IHEN = 16;
  localparam int OSC_WUL = 14;
  localparam int OSC_EINEN = 11;
  localparam int OSC_LSSEL = 10;
  localparam int OSC_ELEN = 9;
  localparam int OSC_EHEN = 8;
  localparam int OSC_WUSPD = 3;
  localparam int OSC_WURUN = 1;
  localparam int OSC_WUGO = 0;
  localparam int STB_PINS = 16;
  localparam int STB_LSAFT = 9;
  localparam int STB_HSAFT = 8;
  localparam int STB_MODE = 0;
  localparam int SPD_REQ = 1;
  localparam int SPD_STATE = 0;
  // ******************************
  // Codes
  // ******************************
  localparam logic [2:0] GEAR_D1 = 3'h0;
  localparam logic [2:0] GEAR_D2 = 3'h4;
  localparam logic [2:0] GEAR_D4 = 3'h5;
  localparam logic [2:0] GEAR_D8 = 3'h6;
  localparam logic [2:0] GEAR_D16 = 3'h7;
  localparam logic [2:0] PRE_MAX = 3'h5;
  localparam logic [1:0] CKO_LS = 2'h0;
  localparam logic [1:0] CKO_SYSD2 = 2'h1;
  localparam logic [1:0] CKO_SYS = 2'h2;
  // ******************************
  // Timing
  // ******************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_PIN_HOLD_NS = 1600000;
  localparam int RST_PIN_CYCLES = RST_PIN_HOLD_NS / CLK_PERIOD_NS;
  localparam int RST_SOFT_OSC_CYCLES = 30;
  localparam int RST_CNT_W = 20;
  // ******************************
  // Carriers
  // ******************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } crmc_wb_req_s;
  typedef struct packed {
    logic int_hs_osc_enable;
    logic ext_hs_osc_enable;
    logic ext_ls_osc_enable;
    logic ext_hs_input_enable;
    logic ext_crystal_use;
    logic hs_oscillator_select;
    logic ls_source_select;
    logic hs_input_pin_select;
  } crmc_osc_s;
  typedef struct packed {
    logic [2:0] low_power_mode_select;
    logic pins_active_in_stop;
    logic hs_osc_after_stop;
    logic ls_osc_after_stop;
  } crmc_low_power_mode_select_s;
  typedef enum logic [1:0] {
    RS_PIN = 2'h0,
    RS_HOLD = 2'h1,
    RS_RUN = 2'h3,
    RS_SOFT = 2'h2
  } crmc_rst_e;
endpackage : crmc_pkg

/* File: rtl/crmc_top.sv */
// Clock, reset and standby-mode controller with a Wishbone register slave.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module crmc_top #(
  parameter int RST_HOLD_CYCLES = crmc_pkg::RST_PIN_CYCLES
) (
  input wire logic clk_i,  // internal high-speed oscillator clock
  input wire logic rst_i,  // power-on reset, active high
  input wire crmc_pkg::crmc_wb_req_s wb_req_i,  // Wishbone request
  output logic wb_ack_o,  // Wishbone acknowledge
  output logic [31:0] wb_dat_o,  // Wishbone read data
  input wire logic reset_pin_n_i,  // external reset pin, active low
  input wire logic watchdog_timer_reset_i,  // watchdog reset pulse
  input wire logic cpu_system_reset_request_i,  // CPU reset request
  input wire logic ext_hs_osc_i,  // external high-speed oscillator
  input wire logic ext_hs_in_i,  // external high-speed clock pin
  input wire logic ls_osc_i,  // external low-speed oscillator
  input wire logic ls_in_i,  // external low-speed clock pin
  output logic sys_reset_o,  // internal reset, active high
  output logic sys_tick_o,  // system clock enable
  output logic prescaler_clock_o,  // prescaler clock enable
  output logic periph_tick_o,  // peripheral clock enable
  output logic converter_clk_en_o,  // converter clock running
  output logic clock_out_pin_o,  // clock output pin
  output crmc_pkg::crmc_osc_s osc_o,  // oscillator controls
  output crmc_pkg::crmc_low_power_mode_select_s low_power_mode_select_o  // standby controls
);
  // ******************************
  // Pin synchronisers
  // ******************************
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_rise;
  assign pin_raw = {reset_pin_n_i, ls_in_i, ls_osc_i, ext_hs_in_i, ext_hs_osc_i};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        pin_s1_r[gi] <= pin_raw[gi];
        pin_s2_r[gi] <= pin_s1_r[gi];
        pin_s3_r[gi] <= pin_s2_r[gi];
      end
      assign pin_rise[gi] = pin_s2_r[gi] & ~pin_s3_r[gi];
    end
  endgenerate
  logic pin_low;
  assign pin_low = ~pin_s2_r[4];

  // ******************************
  // Reset sequencer
  // ******************************
  crmc_pkg::crmc_rst_e rst_st_r, rst_st_nxt;
  logic [crmc_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
  logic [2:0] rst_flg_r, rst_flg_nxt;
  localparam logic [crmc_pkg::RST_CNT_W-1:0] HOLD_LAST =
    crmc_pkg::RST_CNT_W'(RST_HOLD_CYCLES - 1);
  localparam logic [crmc_pkg::RST_CNT_W-1:0] SOFT_LAST =
    crmc_pkg::RST_CNT_W'(crmc_pkg::RST_SOFT_OSC_CYCLES - 1);
  always_comb
  begin
    rst_st_nxt = rst_st_r;
    rst_cnt_nxt = rst_cnt_r + 1'b1;
    rst_flg_nxt = rst_flg_r;
    if (pin_low)
    begin
      rst_st_nxt = crmc_pkg::RS_PIN;
      rst_cnt_nxt = '0;
      rst_flg_nxt = 3'h1;
    end
    else
    begin
      unique case (rst_st_r)
        crmc_pkg::RS_PIN:
        begin
          rst_st_nxt = crmc_pkg::RS_HOLD;
          rst_cnt_nxt = '0;
        end
        crmc_pkg::RS_HOLD:
          if (rst_cnt_r == HOLD_LAST)
            rst_st_nxt = crmc_pkg::RS_RUN;
        crmc_pkg::RS_SOFT:
          if (rst_cnt_r == SOFT_LAST)
            rst_st_nxt = crmc_pkg::RS_RUN;
        crmc_pkg::RS_RUN:
        begin
          rst_cnt_nxt = '0;
          if (watchdog_timer_reset_i | cpu_system_reset_request_i)
          begin
            rst_st_nxt = crmc_pkg::RS_SOFT;
            rst_flg_nxt = {cpu_system_reset_request_i, watchdog_timer_reset_i, 1'b0};
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_st_r <= crmc_pkg::RS_PIN;
      rst_cnt_r <= '0;
      rst_flg_r <= 3'h1;
    end
    else
    begin
      rst_st_r <= rst_st_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      rst_flg_r <= rst_flg_nxt;
    end
  end
  logic srst;
  assign srst = rst_i | (rst_st_r != crmc_pkg::RS_RUN);
  assign sys_reset_o = srst;

  // ******************************
  // Register slave
  // ******************************
  logic [31:0] sys_r, sys_nxt, osc_r, osc_nxt, stb_r, stb_nxt;
  logic [31:0] ext_r, ext_nxt, spd_r, spd_nxt, rdat_nxt;
  logic ack_nxt, acc, wr, wu_go;
  logic wu_run_r;
  logic spd_state_r, spd_state_nxt;
  logic [31:0] bmask;
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [31:0] bm, input logic [31:0] wm);
    logic [31:0] m;
    m = bm & wm;
    return (old & ~m) | (dat & m);
  endfunction : wmerge
  assign acc = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr = acc & wb_req_i.we;
  assign bmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  always_comb
  begin
    sys_nxt = sys_r;
    osc_nxt = osc_r;
    stb_nxt = stb_r;
    ext_nxt = ext_r;
    spd_nxt = spd_r;
    ack_nxt = acc;
    wu_go = 1'b0;
    rdat_nxt = '0;
    if (wr)
    begin
      unique case (wb_req_i.adr)
        crmc_pkg::SYSCTL_OFS: sys_nxt = wmerge(sys_r, wb_req_i.dat, bmask, crmc_pkg::SYSCTL_WMASK);
        crmc_pkg::OSCCTL_OFS:
        begin
          osc_nxt = wmerge(osc_r, wb_req_i.dat, bmask, crmc_pkg::OSCCTL_WMASK);
          wu_go = wb_req_i.sel[0] & wb_req_i.dat[crmc_pkg::OSC_WUGO];
        end
        crmc_pkg::STBYCTL_OFS: stb_nxt = wmerge(stb_r, wb_req_i.dat, bmask, crmc_pkg::STBYCTL_WMASK);
        crmc_pkg::EXTSEL_OFS: ext_nxt = wmerge(ext_r, wb_req_i.dat, bmask, crmc_pkg::EXTSEL_WMASK);
        crmc_pkg::SPDSEL_OFS: spd_nxt = wmerge(spd_r, wb_req_i.dat, bmask, crmc_pkg::SPDSEL_WMASK);
        default: ;
      endcase
    end
    if (acc & ~wb_req_i.we)
    begin
      unique case (wb_req_i.adr)
        crmc_pkg::SYSCTL_OFS: rdat_nxt = sys_r;
        crmc_pkg::OSCCTL_OFS: rdat_nxt = osc_r | (32'(wu_run_r) << crmc_pkg::OSC_WURUN);
        crmc_pkg::STBYCTL_OFS: rdat_nxt = stb_r;
        crmc_pkg::EXTSEL_OFS: rdat_nxt = ext_r;
        crmc_pkg::SPDSEL_OFS: rdat_nxt = spd_r | (32'(spd_state_r) << crmc_pkg::SPD_STATE);
        crmc_pkg::RSTFLG_OFS: rdat_nxt = {29'h0, rst_flg_r};
        default: rdat_nxt = '0;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (srst)
    begin
      sys_r <= crmc_pkg::SYSCTL_RST;
      osc_r <= crmc_pkg::OSCCTL_RST;
      stb_r <= crmc_pkg::STBYCTL_RST;
      ext_r <= crmc_pkg::EXTSEL_RST;
      spd_r <= crmc_pkg::SPDSEL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      sys_r <= sys_nxt;
      osc_r <= osc_nxt;
      stb_r <= stb_nxt;
      ext_r <= ext_nxt;
      spd_r <= spd_nxt;
      wb_ack_o <= ack_nxt;
      wb_dat_o <= rdat_nxt;
    end
  end
  assign osc_o.int_hs_osc_enable = osc_r[crmc_pkg::OSC_IHEN];
  assign osc_o.ext_hs_osc_enable = osc_r[crmc_pkg::OSC_EHEN];
  assign osc_o.ext_ls_osc_enable = osc_r[crmc_pkg::OSC_ELEN];
  assign osc_o.ext_hs_input_enable = osc_r[crmc_pkg::OSC_EINEN];
  assign osc_o.ext_crystal_use = osc_r[crmc_pkg::OSC_XUSE];
  assign osc_o.hs_oscillator_select = osc_r[crmc_pkg::OSC_HSSEL];
  assign osc_o.ls_source_select = osc_r[crmc_pkg::OSC_LSSEL];
  assign osc_o.hs_input_pin_select = ext_r[crmc_pkg::SPD_STATE];
  assign low_power_mode_select_o.low_power_mode_select = stb_r[crmc_pkg::STB_MODE +: 3];
  assign low_power_mode_select_o.pins_active_in_stop = stb_r[crmc_pkg::STB_PINS];
  assign low_power_mode_select_o.hs_osc_after_stop = stb_r[crmc_pkg::STB_HSAFT];
  assign low_power_mode_select_o.ls_osc_after_stop = stb_r[crmc_pkg::STB_LSAFT];
  assign converter_clk_en_o = ~sys_r[crmc_pkg::SYS_ADCSTOP];

  // ******************************
  // Clock sources
  // ******************************
  logic ehosc_tick, ein_tick, lsosc_tick, lsin_tick, hs_tick, ls_tick;
  assign ehosc_tick = pin_rise[0] & osc_r[crmc_pkg::OSC_EHEN];
  assign ein_tick = pin_rise[1] & osc_r[crmc_pkg::OSC_EINEN];
  assign lsosc_tick = pin_rise[2] & osc_r[crmc_pkg::OSC_ELEN];
  assign lsin_tick = pin_rise[3];
  assign ls_tick = osc_r[crmc_pkg::OSC_LSSEL] ? lsin_tick : lsosc_tick;
  always_comb
  begin
    if (ext_r[crmc_pkg::SPD_STATE])
      hs_tick = ein_tick;
    else if (osc_r[crmc_pkg::OSC_HSSEL])
      hs_tick = ehosc_tick;
    else
      hs_tick = osc_r[crmc_pkg::OSC_IHEN];
  end

  // ******************************
  // Gear, speed switch and prescaler
  // ******************************
  logic [3:0] gcnt_r, gcnt_nxt, gdiv_r, gdiv_nxt, gdiv_req;
  logic [4:0] pcnt_r, pcnt_nxt, pdiv_r, pdiv_nxt, pdiv_req;
  logic gear_tick, pbase_tick, pre_tick;
  logic [2:0] gear_f, pre_f;
  assign gear_f = sys_r[crmc_pkg::SYS_GEAR +: 3];
  assign pre_f = sys_r[crmc_pkg::SYS_PRE +: 3];
  always_comb
  begin
    unique case (gear_f)
      crmc_pkg::GEAR_D1: gdiv_req = 4'h0;
      crmc_pkg::GEAR_D2: gdiv_req = 4'h1;
      crmc_pkg::GEAR_D4: gdiv_req = 4'h3;
      crmc_pkg::GEAR_D8: gdiv_req = 4'h7;
      crmc_pkg::GEAR_D16: gdiv_req = 4'hF;
      default: gdiv_req = gdiv_r;
    endcase
    pdiv_req = (pre_f > crmc_pkg::PRE_MAX) ? pdiv_r : 5'((6'h01 << pre_f) - 6'h01);
    gear_tick = hs_tick & (gcnt_r == gdiv_r);
    gcnt_nxt = gcnt_r;
    gdiv_nxt = gdiv_r;
    if (hs_tick)
      gcnt_nxt = gear_tick ? 4'h0 : gcnt_r + 4'h1;
    if (gear_tick | (gcnt_r == 4'h0))
      gdiv_nxt = gdiv_req;
    pbase_tick = sys_r[crmc_pkg::SYS_PBASE] ? hs_tick : gear_tick;
    pre_tick = pbase_tick & (pcnt_r == pdiv_r);
    pcnt_nxt = pcnt_r;
    pdiv_nxt = pdiv_r;
    if (pbase_tick)
      pcnt_nxt = pre_tick ? 5'h00 : pcnt_r + 5'h01;
    if (pre_tick | (pcnt_r == 5'h00))
      pdiv_nxt = pdiv_req;
    spd_state_nxt = spd_state_r;
    if (spd_r[crmc_pkg::SPD_REQ] & ls_tick)
      spd_state_nxt = 1'b1;
    else if (~spd_r[crmc_pkg::SPD_REQ] & gear_tick)
      spd_state_nxt = 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst)
    begin
      gcnt_r <= '0;
      gdiv_r <= '0;
      pcnt_r <= '0;
      pdiv_r <= '0;
      spd_state_r <= 1'b0;
    end
    else
    begin
      gcnt_r <= gcnt_nxt;
      gdiv_r <= gdiv_nxt;
      pcnt_r <= pcnt_nxt;
      pdiv_r <= pdiv_nxt;
      spd_state_r <= spd_state_nxt;
    end
  end
  assign sys_tick_o = spd_state_r ? ls_tick : gear_tick;
  assign prescaler_clock_o = pre_tick;
  assign periph_tick_o = sys_r[crmc_pkg::SYS_PBYP] ? sys_tick_o : pre_tick;

  // ******************************
  // Clock output pin
  // ******************************
  logic cko_r, cko_nxt;
  always_comb
  begin
    unique case (sys_r[crmc_pkg::SYS_CKOUT +: 2])
      crmc_pkg::CKO_LS: cko_nxt = cko_r ^ ls_tick;
      crmc_pkg::CKO_SYSD2: cko_nxt = cko_r ^ sys_tick_o;
      crmc_pkg::CKO_SYS: cko_nxt = sys_tick_o;
      default: cko_nxt = cko_r ^ pre_tick;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (srst)
      cko_r <= 1'b0;
    else
      cko_r <= cko_nxt;
  end
  assign clock_out_pin_o = cko_r;

  // ******************************
  // Warm-up timer
  // ******************************
  logic [15:0] wu_cnt_r, wu_cnt_nxt;
  logic wu_run_nxt, wu_tick;
  always_comb
  begin
    if (osc_r[crmc_pkg::OSC_WUSPD])
      wu_tick = ls_tick;
    else
      wu_tick = osc_r[crmc_pkg::OSC_WUHS] ? ehosc_tick : osc_r[crmc_pkg::OSC_IHEN];
    wu_cnt_nxt = wu_cnt_r;
    wu_run_nxt = wu_run_r;
    if (wu_go)
    begin
      wu_cnt_nxt = {osc_nxt[crmc_pkg::OSC_WUH +: 12], osc_nxt[crmc_pkg::OSC_WUL +: 2], 2'h0};
      wu_run_nxt = 1'b1;
    end
    else if (wu_run_r & wu_tick)
    begin
      if (wu_cnt_r <= 16'h0001)
        wu_run_nxt = 1'b0;
      wu_cnt_nxt = (wu_cnt_r == 16'h0000) ? 16'h0000 : wu_cnt_r - 16'h0001;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (srst)
    begin
      wu_cnt_r <= '0;
      wu_run_r <= 1'b0;
    end
    else
    begin
      wu_cnt_r <= wu_cnt_nxt;
      wu_run_r <= wu_run_nxt;
    end
  end
endmodule : crmc_top

/* File: verif/crmc_top_chk.sv */
// Assertion checker bound to the clock, reset and mode controller ports.
`timescale 1ns/1ps
module crmc_top_chk #(
  parameter int RST_HOLD_CYCLES = 20
) (
  input wire logic clk_i,  // clock
  input wire logic rst_i,  // power-on reset
  input wire crmc_pkg::crmc_wb_req_s wb_req_i,  // bus request
  input wire logic wb_ack_o,  // bus acknowledge
  input wire logic [31:0] wb_dat_o,  // bus read data
  input wire logic reset_pin_n_i,  // reset pin
  input wire logic watchdog_timer_reset_i,  // watchdog reset
  input wire logic cpu_system_reset_request_i,  // cpu reset request
  input wire logic sys_reset_o,  // internal reset
  input wire logic converter_clk_en_o,  // converter clock running
  input wire crmc_pkg::crmc_osc_s osc_o,  // oscillator controls
  input wire crmc_pkg::crmc_low_power_mode_select_s low_power_mode_select_o  // standby controls
);
  // ******************************
  // Cycles since the reset pin went high
  // ******************************
  logic [10:0] hi_cnt_r;
  logic [10:0] hi_cnt_nxt;
  always_comb
  begin
    hi_cnt_nxt = hi_cnt_r;
    if (!reset_pin_n_i)
      hi_cnt_nxt = 11'h000;
    else if (hi_cnt_r != 11'h7FF)
      hi_cnt_nxt = hi_cnt_r + 11'h001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hi_cnt_r <= 11'h000;
    else
      hi_cnt_r <= hi_cnt_nxt;
  end
  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property
    ((wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && !sys_reset_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_qualified: assert property (wb_ack_o |-> (wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_unmapped_zero: assert property
    ((wb_ack_o && !wb_req_i.we && wb_req_i.adr > crmc_pkg::RSTFLG_OFS) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_pin_asserts: assert property (!reset_pin_n_i |-> ##[0:4] sys_reset_o)
    else $error("reset pin did not raise internal reset");
  a_pin_release: assert property (($fell(sys_reset_o) && hi_cnt_r < 11'h064) |->
    (hi_cnt_r >= RST_HOLD_CYCLES && hi_cnt_r <= RST_HOLD_CYCLES + 6))
    else $error("pin reset released at wrong time");
  a_soft_hold: assert property
    (((watchdog_timer_reset_i || cpu_system_reset_request_i) && !sys_reset_o) |=>
      sys_reset_o [*8] ##[18:26] $fell(sys_reset_o))
    else $error("soft reset length wrong");
  a_conv_gate: assert property ((wb_ack_o && wb_req_i.we && !sys_reset_o &&
    wb_req_i.adr == crmc_pkg::SYSCTL_OFS && wb_req_i.sel[2]) |=>
    converter_clk_en_o == !$past(wb_req_i.dat[20]))
    else $error("converter clock gate wrong");
  a_reset_clocks: assert property ($fell(sys_reset_o) |->
    (osc_o.int_hs_osc_enable && !osc_o.hs_oscillator_select &&
     !osc_o.hs_input_pin_select && converter_clk_en_o &&
     low_power_mode_select_o.low_power_mode_select == 3'h3))
    else $error("clock state after reset wrong");
endmodule : crmc_top_chk

bind crmc_top crmc_top_chk #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .reset_pin_n_i(reset_pin_n_i),
  .watchdog_timer_reset_i(watchdog_timer_reset_i),
  .cpu_system_reset_request_i(cpu_system_reset_request_i),
  .sys_reset_o(sys_reset_o),
  .converter_clk_en_o(converter_clk_en_o),
  .osc_o(osc_o),
  .low_power_mode_select_o(low_power_mode_select_o)
);

/* File: verif/tb_crmc_top.sv */
// Self-checking bench for the clock, reset and mode controller.
`timescale 1ns/1ps
module tb_crmc_top;
  localparam int HOLD = 20;
  // Divider settings of the tick scenario, and per setting the counts of sys, prescaler,
  // peripheral pulses and clock-out rises that 64 cycles must hold, one byte each.
  localparam logic [3:0][31:0] TCFG =
    {32'h0002_0004, 32'h0000_0000, 32'h0003_3206, 32'h0001_0105};
  localparam logic [3:0][31:0] TEXP =
    {32'h2020_2020, 32'h4040_4002, 32'h0810_0808, 32'h1008_0808};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  crmc_pkg::crmc_wb_req_s req_r = '0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic pin_n_r = 1'b0;
  logic wd_r = 1'b0;
  logic cpu_r = 1'b0;
  logic [3:0] ext_r = 4'h0;
  logic sys_reset_o;
  logic conv_o;
  logic sys_o, pre_o, per_o, cko_o;
  crmc_pkg::crmc_osc_s osc_o;
  crmc_pkg::crmc_low_power_mode_select_s low_power_mode_select_o;
  int n_fail = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int n;
  logic [31:0] rd;
  crmc_top #(.RST_HOLD_CYCLES(HOLD)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req_r), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .reset_pin_n_i(pin_n_r), .watchdog_timer_reset_i(wd_r),
    .cpu_system_reset_request_i(cpu_r), .ext_hs_osc_i(ext_r[0]), .ext_hs_in_i(ext_r[1]),
    .ls_osc_i(ext_r[3]), .ls_in_i(ext_r[2]), .sys_reset_o(sys_reset_o), .sys_tick_o(sys_o),
    .prescaler_clock_o(pre_o), .periph_tick_o(per_o), .converter_clk_en_o(conv_o),
    .clock_out_pin_o(cko_o), .osc_o(osc_o), .low_power_mode_select_o(low_power_mode_select_o)
  );
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    ext_r <= ext_r + 4'h1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [4:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    req_r <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    req_r <= '0;
    if (k >= 50)
      chk(32'h0, 32'h1);
  endtask : wb
  task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, 4'hF, dat, rd);
  endtask : wr
  task automatic rdchk(input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 4'hF, 32'h0, q);
    chk(q, exp);
  endtask : rdchk
  task automatic rel_len(output int c);
    c = 0;
    while (sys_reset_o !== 1'b0 && c < 3000)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask : rel_len
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_regs();
    rdchk(crmc_pkg::SYSCTL_OFS, 32'h0001_0000);
    rdchk(crmc_pkg::OSCCTL_OFS, 32'h8001_0030);
    rdchk(crmc_pkg::STBYCTL_OFS, 32'h0000_0103);
    rdchk(crmc_pkg::EXTSEL_OFS, 32'h0000_721E);
    rdchk(crmc_pkg::SPDSEL_OFS, 32'h0);
    rdchk(crmc_pkg::RSTFLG_OFS, 32'h1);
    wr(crmc_pkg::SYSCTL_OFS, 32'hFFFF_FFFF);
    rdchk(crmc_pkg::SYSCTL_OFS, 32'h0013_3707);
    @(negedge clk_i);
    chk({31'h0, conv_o}, 32'h0);
    wb(1'b1, crmc_pkg::SYSCTL_OFS, 4'h1, 32'h0, rd);
    rdchk(crmc_pkg::SYSCTL_OFS, 32'h0013_3700);
    wr(crmc_pkg::SYSCTL_OFS, 32'h0);
    @(negedge clk_i);
    chk({31'h0, conv_o}, 32'h1);
    wr(5'h18, 32'hFFFF_FFFF);
    rdchk(5'h18, 32'h0);
    wr(crmc_pkg::RSTFLG_OFS, 32'hFFFF_FFFF);
    rdchk(crmc_pkg::RSTFLG_OFS, 32'h1);
  endtask : t_regs
  task automatic t_osc();
    wr(crmc_pkg::OSCCTL_OFS, 32'hFFFF_FFFE);
    rdchk(crmc_pkg::OSCCTL_OFS, 32'hFFFF_CF38);
    chk({24'h0, osc_o}, 32'h0000_00FE);
    wr(crmc_pkg::EXTSEL_OFS, 32'hFFFF_FFFF);
    rdchk(crmc_pkg::EXTSEL_OFS, 32'h0000_721F);
    chk({24'h0, osc_o}, 32'h0000_00FF);
    wr(crmc_pkg::EXTSEL_OFS, 32'h0);
    wr(crmc_pkg::OSCCTL_OFS, 32'h0011_0001);
    rdchk(crmc_pkg::OSCCTL_OFS, 32'h0011_0032);
    repeat (40) @(posedge clk_i);
    rdchk(crmc_pkg::OSCCTL_OFS, 32'h0011_0030);
    wr(crmc_pkg::OSCCTL_OFS, 32'h8001_0230);
    wr(crmc_pkg::SPDSEL_OFS, 32'h2);
    repeat (100) @(posedge clk_i);
    rdchk(crmc_pkg::SPDSEL_OFS, 32'h3);
    wr(crmc_pkg::SPDSEL_OFS, 32'h0);
    repeat (50) @(posedge clk_i);
    rdchk(crmc_pkg::SPDSEL_OFS, 32'h0);
  endtask : t_osc
  task automatic t_low_power_mode_select();
    for (int m = 1; m <= 3; m++)
    begin
      wr(crmc_pkg::STBYCTL_OFS, 32'h0001_0300 | m);
      rdchk(crmc_pkg::STBYCTL_OFS, 32'h0001_0300 | m);
      chk({26'h0, low_power_mode_select_o}, {26'h0, m[2:0], 3'h7});
    end
  endtask : t_low_power_mode_select
  // Counts enable pulses and clock-out rises over 64 cycles for each divider setting.
  task automatic t_ticks();
    logic [7:0] ns, np, nq, nr;
    logic last;
    for (int c = 0; c < 4; c++)
    begin
      wr(crmc_pkg::SYSCTL_OFS, TCFG[c]);
      repeat (40) @(posedge clk_i);
      ns = 8'h00;
      np = 8'h00;
      nq = 8'h00;
      nr = 8'h00;
      @(negedge clk_i);
      last = cko_o;
      repeat (64)
      begin
        @(negedge clk_i);
        ns = ns + {7'h00, sys_o === 1'b1};
        np = np + {7'h00, pre_o === 1'b1};
        nq = nq + {7'h00, per_o === 1'b1};
        nr = nr + {7'h00, (cko_o === 1'b1) && (last === 1'b0)};
        last = cko_o;
      end
      chk({24'h0, ns}, {24'h0, TEXP[c][31:24]});
      chk({24'h0, np}, {24'h0, TEXP[c][23:16]});
      chk({24'h0, nq}, {24'h0, TEXP[c][15:8]});
      chk({24'h0, nr}, {24'h0, TEXP[c][7:0]});
    end
    wr(crmc_pkg::SYSCTL_OFS, 32'h0);
  endtask : t_ticks
  task automatic t_soft();
    for (int s = 0; s < 2; s++)
    begin
      wr(crmc_pkg::SYSCTL_OFS, 32'h0010_0000);
      @(posedge clk_i);
      wd_r <= (s == 0);
      cpu_r <= (s == 1);
      @(posedge clk_i);
      wd_r <= 1'b0;
      cpu_r <= 1'b0;
      @(negedge clk_i);
      chk({31'h0, sys_reset_o}, 32'h1);
      rel_len(n);
      chk({31'h0, (n >= 28 && n <= 33)}, 32'h1);
      rdchk(crmc_pkg::RSTFLG_OFS, (s == 0) ? 32'h2 : 32'h4);
      rdchk(crmc_pkg::SYSCTL_OFS, 32'h0001_0000);
    end
  endtask : t_soft
  task automatic t_pin();
    @(posedge clk_i);
    pin_n_r <= 1'b0;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, sys_reset_o}, 32'h1);
    @(posedge clk_i);
    pin_n_r <= 1'b1;
    rel_len(n);
    chk({31'h0, (n >= HOLD && n <= HOLD + 6)}, 32'h1);
    rdchk(crmc_pkg::RSTFLG_OFS, 32'h1);
    rdchk(crmc_pkg::STBYCTL_OFS, 32'h0000_0103);
  endtask : t_pin
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    pin_n_r <= 1'b1;
    rel_len(n);
    t_regs();
    t_osc();
    t_low_power_mode_select();
    t_ticks();
    t_soft();
    t_pin();
    wrap_up();
  end
endmodule : tb_crmc_top
